// file: verilog/adcc_top.sv
// conversion control: apb registers, start/abort sequencing, done flag and result latching
// ==========================================================
// Notes on behaviour
// - writing the control register aborts and, with register-write trigger, restarts unless channel is all ones
// - done flag is read-only, set on every finish without compare
// - with compare on, done flag sets only when compare holds
// - done flag clears on control register write or low result read
// - interrupt asserts when done flag is set and interrupt enable is one
// - without continuous mode one conversion per start
// - with continuous mode conversions repeat after the starting event
// - channel field is five bits, with reference and reserved codes
// - channel all ones powers converter off and isolates inputs
// - stopping with all ones starts no extra conversion
// - single mode drops to low power after a conversion
// - active status sets on start, clears on a single-mode finish or on an abort without restart
// - trigger select chooses register write or hardware trigger
// - compare is less-than by default, greater-or-equal when selected
// - in ten-bit mode a high result read locks results until low read
`include "adcc_defs.svh"

module adcc_top
  import adcc_pkg::*;
#(
  parameter int RES_W = 10              // converter resolution
) (
  input  wire logic             sys_clk_i,      // module clock, 20 MHz
  input  wire logic             resetn_i,       // async reset, active low
  input  wire logic             ce_i,           // clock enable, freezes state
  input  wire logic             psel_i,         // apb select
  input  wire logic             penable_i,      // apb enable
  input  wire logic             pwrite_i,       // apb direction
  input  wire logic [5:0]       paddr_i,        // apb byte address
  input  wire logic [31:0]      pwdata_i,       // apb write data
  output logic      [31:0]      prdata_o,       // apb read data
  output logic                  pready_o,       // apb ready
  output logic                  pslverr_o,      // apb error, unmapped address
  input  wire logic             hw_trigger_input_i, // hardware trigger pin
  input  wire logic             conv_done_i,    // analog core finished, pulse
  input  wire logic [RES_W-1:0] conv_result_i,  // analog core result
  output logic                  conv_start_o,   // start pulse to core
  output logic                  conv_abort_o,   // abort pulse to core
  output logic      [4:0]       channel_o,      // selected input code
  output logic                  power_on_o,     // converter powered, inputs connected
  output logic                  done_irq_o      // conversion interrupt, level
);

  // ==========================================================
  // register state
  adcc_state_t      state;
  logic             conversion_done_flag;
  logic             done_irq_enable;
  logic             continuous_enable;
  logic [4:0]       channel_select;
  logic             trigger_select;
  logic             compare_enable;
  logic             compare_greater_select;
  logic             ten_bit_mode;
  logic [1:0]       result_high_reg;
  logic [7:0]       result_low_reg;
  logic [1:0]       compare_high;
  logic [7:0]       compare_low;
  logic             result_lock;
  logic             hw_s1;
  logic             hw_s2;
  logic             hw_s3;
  logic             hw_level;

  // ==========================================================
  // bus decode
  logic             setup_ph;
  logic             acc_wr;
  logic             acc_rd;
  logic             wr_sc1;
  logic             rd_rl;
  logic             rd_rh;
  logic             addr_ok;
  logic             new_off;
  logic             hw_rise;
  logic             sw_start;
  logic             hw_start;
  logic             restart;
  logic             start;
  logic             fin;
  logic             cmp_true;
  logic             done_ok;
  logic [9:0]       res_val;
  logic [9:0]       cmp_val;

  // every access finishes in its first access cycle
  assign setup_ph = psel_i & ~penable_i;
  assign acc_wr   = psel_i & penable_i & pwrite_i & pready_o;
  assign acc_rd   = psel_i & penable_i & ~pwrite_i & pready_o;
  assign wr_sc1   = acc_wr & (paddr_i == `ADCC_OFS_SC1);
  assign rd_rl    = acc_rd & (paddr_i == `ADCC_OFS_RL);
  assign rd_rh    = acc_rd & (paddr_i == `ADCC_OFS_RH);
  assign addr_ok  = (paddr_i == `ADCC_OFS_SC1) | (paddr_i == `ADCC_OFS_SC2) |
                    (paddr_i == `ADCC_OFS_RH)  | (paddr_i == `ADCC_OFS_RL)  |
                    (paddr_i == `ADCC_OFS_CVH) | (paddr_i == `ADCC_OFS_CVL) |
                    (paddr_i == `ADCC_OFS_CFG);

  // ==========================================================
  // start and finish conditions
  assign new_off  = (pwdata_i[4:0] == `ADCC_CH_OFF);
  assign hw_rise  = (hw_s2 == hw_s3) & hw_s2 & ~hw_level;
  // a write with the off code starts nothing, so no trailing conversion
  assign sw_start = wr_sc1 & ~new_off & ~trigger_select;
  // further triggers are ignored while a conversion runs
  assign hw_start = ~wr_sc1 & hw_rise & trigger_select & (state == ADCC_IDLE) &
                    (channel_select != `ADCC_CH_OFF);
  // a finish beside a control write belongs to the aborted conversion and is dropped
  assign fin      = ~wr_sc1 & (state == ADCC_CONV) & conv_done_i;
  // continuous mode relaunches straight from the finish, no new trigger needed
  assign restart  = fin & continuous_enable;
  assign start    = sw_start | hw_start | restart;

  // ==========================================================
  // compare, 8-bit mode takes the top bits and compares low byte only
  assign res_val  = ten_bit_mode ? conv_result_i[9:0] : {2'h0, conv_result_i[9:2]};
  assign cmp_val  = ten_bit_mode ? {compare_high, compare_low} : {2'h0, compare_low};
  assign cmp_true = compare_greater_select ? (res_val >= cmp_val)
                                           : (res_val < cmp_val);
  assign done_ok  = fin & (~compare_enable | cmp_true);

  // ==========================================================
  // hardware trigger pin synchroniser, change counts when stages 2 and 3 agree
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hw_s1    <= 1'b0;
      hw_s2    <= 1'b0;
      hw_s3    <= 1'b0;
      hw_level <= 1'b0;
    end else if (ce_i) begin
      hw_s1 <= hw_trigger_input_i;
      hw_s2 <= hw_s1;
      hw_s3 <= hw_s2;
      if (hw_s2 == hw_s3) begin
        hw_level <= hw_s2;
      end
    end
  end

  // ==========================================================
  // sequencer: a control write overrides a finish in the same cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ADCC_IDLE;
    end else if (ce_i) begin
      if (wr_sc1) begin
        state <= sw_start ? ADCC_CONV : ADCC_IDLE;
      end else if (fin) begin
        state <= restart ? ADCC_CONV : ADCC_IDLE;
      end else if (hw_start) begin
        state <= ADCC_CONV;
      end
    end
  end

  // converter power follows the sequencer, so it doubles as the active status
  // single mode falls back to low power on its own, no off code needed
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_on_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_sc1) begin
        power_on_o <= sw_start;
      end else if (fin) begin
        power_on_o <= restart;
      end else if (hw_start) begin
        power_on_o <= 1'b1;
      end
    end
  end

  // one-cycle pulses to the core; a restarting write raises both at once,
  // so the core must give the start priority or the new conversion is lost
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_start_o <= 1'b0;
      conv_abort_o <= 1'b0;
    end else if (ce_i) begin
      conv_start_o <= start;
      conv_abort_o <= wr_sc1 & (state == ADCC_CONV);
    end
  end

  // ==========================================================
  // done flag: hardware set wins over a low result read clear in the same cycle; a control write drops the finish
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conversion_done_flag <= 1'b0;
    end else if (ce_i) begin
      if (done_ok) begin
        conversion_done_flag <= 1'b1;
      end else if (wr_sc1 | rd_rl) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // interrupt follows the flag gated by its enable
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_irq_o <= 1'b0;
    end else if (ce_i) begin
      done_irq_o <= conversion_done_flag & done_irq_enable;
    end
  end

  // ==========================================================
  // first control register fields, written as a whole by software
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_irq_enable   <= 1'b0;
      continuous_enable <= 1'b0;
      channel_select    <= `ADCC_CH_RESET;
    end else if (ce_i) begin
      if (wr_sc1) begin
        done_irq_enable   <= pwdata_i[`ADCC_SC1_IEN];
        continuous_enable <= pwdata_i[`ADCC_SC1_CONT];
        channel_select    <= pwdata_i[4:0];
      end
    end
  end

  // trigger and compare mode bits; the active bit beside them is read-only
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trigger_select         <= 1'b0;
      compare_enable         <= 1'b0;
      compare_greater_select <= 1'b0;
    end else if (ce_i) begin
      if (acc_wr & (paddr_i == `ADCC_OFS_SC2)) begin
        trigger_select         <= pwdata_i[`ADCC_SC2_TRIG];
        compare_enable         <= pwdata_i[`ADCC_SC2_CMPEN];
        compare_greater_select <= pwdata_i[`ADCC_SC2_CMPGT];
      end
    end
  end

  // compare value halves; the high half is ignored in 8-bit mode
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_high <= 2'h0;
      compare_low  <= 8'h00;
    end else if (ce_i) begin
      if (acc_wr & (paddr_i == `ADCC_OFS_CVH)) begin
        compare_high <= pwdata_i[1:0];
      end
      if (acc_wr & (paddr_i == `ADCC_OFS_CVL)) begin
        compare_low <= pwdata_i[7:0];
      end
    end
  end

  // resolution select; switching it leaves stale data in the result registers
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ten_bit_mode <= `ADCC_TENBIT_RESET;
    end else if (ce_i) begin
      if (acc_wr & (paddr_i == `ADCC_OFS_CFG)) begin
        ten_bit_mode <= pwdata_i[`ADCC_CFG_TENBIT];
      end
    end
  end

  // channel code straight to the analog mux; all ones means isolated
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      channel_o <= `ADCC_CH_RESET;
    end else if (ce_i) begin
      if (wr_sc1) begin
        channel_o <= pwdata_i[4:0];
      end
    end
  end

  // ==========================================================
  // result registers and the high-then-low read interlock
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_lock <= 1'b0;
    end else if (ce_i) begin
      if (~ten_bit_mode | rd_rl) begin
        result_lock <= 1'b0;
      end else if (rd_rh) begin
        result_lock <= 1'b1;
      end
    end
  end

  // a result finishing while locked is lost, which software must accept
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_high_reg <= 2'h0;
      result_low_reg  <= 8'h00;
    end else if (ce_i) begin
      if (done_ok & ~result_lock) begin
        result_high_reg <= res_val[9:8];
        result_low_reg  <= res_val[7:0];
      end
    end
  end

  // ==========================================================
  // apb answer, prepared in setup so it stands through the access cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o <= 1'b0;
    end else if (ce_i) begin
      pready_o <= setup_ph;
    end
  end

  // unmapped addresses answer with an error and touch no register
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      pslverr_o <= setup_ph & ~addr_ok;
    end
  end

  // read data is latched in setup, so software sees the registers as of that edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h00000000;
    end else if (ce_i) begin
      if (setup_ph & ~pwrite_i) begin
        case (paddr_i)
          `ADCC_OFS_SC1: prdata_o <= {24'h000000, conversion_done_flag, done_irq_enable,
                                      continuous_enable, channel_select};
          `ADCC_OFS_SC2: prdata_o <= {24'h000000, (state == ADCC_CONV), trigger_select,
                                      compare_enable, compare_greater_select,
                                      4'h0};
          `ADCC_OFS_RH:  prdata_o <= {30'h00000000, result_high_reg};
          `ADCC_OFS_RL:  prdata_o <= {24'h000000, result_low_reg};
          `ADCC_OFS_CVH: prdata_o <= {30'h00000000, compare_high};
          `ADCC_OFS_CVL: prdata_o <= {24'h000000, compare_low};
          `ADCC_OFS_CFG: prdata_o <= {31'h00000000, ten_bit_mode};
          default:       prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: inc/adcc_defs.svh
// register offsets, field positions and reset values of the conversion control block
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// ==========================================================
// register byte offsets
`define ADCC_OFS_SC1      6'h00
`define ADCC_OFS_SC2      6'h04
`define ADCC_OFS_RH       6'h08
`define ADCC_OFS_RL       6'h0C
`define ADCC_OFS_CVH      6'h10
`define ADCC_OFS_CVL      6'h14
`define ADCC_OFS_CFG      6'h18
// ==========================================================
// field positions
`define ADCC_SC1_DONE     7
`define ADCC_SC1_IEN      6
`define ADCC_SC1_CONT     5
`define ADCC_SC2_ACT      7
`define ADCC_SC2_TRIG     6
`define ADCC_SC2_CMPEN    5
`define ADCC_SC2_CMPGT    4
`define ADCC_CFG_TENBIT   0
// ==========================================================
// codes and reset values
`define ADCC_CH_OFF       5'h1F
`define ADCC_CH_RESET     5'h1F
`define ADCC_TENBIT_RESET 1'h1
`endif

// file: inc/adcc_pkg.sv
// types shared by the conversion control block
package adcc_pkg;
  // converter sequencing states
  typedef enum logic [0:0] {
    ADCC_IDLE,
    ADCC_CONV
  } adcc_state_t;
endpackage

// file: testbench/adcc_top_asserts.sv
// port checker for the conversion control block
module adcc_chk (
  input wire logic        sys_clk_i,    // clock
  input wire logic        resetn_i,     // reset, active low
  input wire logic        psel_i,       // apb select
  input wire logic        penable_i,    // apb enable
  input wire logic        pwrite_i,     // apb direction
  input wire logic [5:0]  paddr_i,      // apb address
  input wire logic [31:0] pwdata_i,     // apb write data
  input wire logic        pready_o,     // apb ready
  input wire logic        conv_done_i,  // core finished
  input wire logic        conv_start_o, // start pulse
  input wire logic        conv_abort_o, // abort pulse
  input wire logic [4:0]  channel_o,    // channel code
  input wire logic        power_on_o,   // converter on
  input wire logic        done_irq_o    // interrupt level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc, wr, fin;
  logic ien, cont, hw, cmp;
  // ==========================================================
  // mirrors of written mode bits, so no internal probes are needed
  assign acc = psel_i & penable_i & pwrite_i & pready_o;
  assign wr  = acc && paddr_i == 6'h00;
  assign fin = conv_done_i && power_on_o && !wr;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {ien, cont, hw, cmp} <= 4'h0;
    end else if (wr) begin
      {ien, cont} <= pwdata_i[6:5];
    end else if (acc && paddr_i == 6'h04) begin
      {hw, cmp} <= pwdata_i[6:5];
    end
  end
  // ==========================================================
  // properties; ce_i is assumed high while these are judged
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_start;
    wr && !hw && pwdata_i[4:0] != 5'h1F |=> conv_start_o && channel_o == $past(pwdata_i[4:0]);
  endproperty
  a_start: assert property (p_start) else $error("no start after write");
  property p_abort; wr && power_on_o |=> conv_abort_o; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_off;
    wr && pwdata_i[4:0] == 5'h1F |=> !conv_start_o && !power_on_o && channel_o == 5'h1F;
  endproperty
  a_off: assert property (p_off) else $error("off code misbehaves");
  property p_clr; wr |=> ##1 !done_irq_o; endproperty
  a_clr: assert property (p_clr) else $error("irq kept after write");
  property p_set; fin && !cmp |=> ##1 done_irq_o == $past(ien); endproperty
  a_set: assert property (p_set) else $error("irq wrong after finish");
  property p_single; fin && !cont |=> !power_on_o; endproperty
  a_single: assert property (p_single) else $error("power kept");
  property p_cont; fin && cont |=> conv_start_o; endproperty
  a_cont: assert property (p_cont) else $error("no restart");
  property p_cause; conv_start_o |-> hw || $past(wr) || $past(conv_done_i); endproperty
  a_cause: assert property (p_cause) else $error("start without cause");
  property p_act; conv_start_o |-> power_on_o; endproperty
  a_act: assert property (p_act) else $error("start while inactive");
  property p_drop; $fell(power_on_o) |-> $past(conv_done_i) || $past(wr); endproperty
  a_drop: assert property (p_drop) else $error("active dropped early");
  c_cont: cover property (fin && cont);
  c_abort: cover property (wr && power_on_o);
  c_cmp: cover property (fin && cmp);
endmodule
bind adcc_top adcc_chk u_chk (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pready_o, .conv_done_i, .conv_start_o, .conv_abort_o, .channel_o,
  .power_on_o, .done_irq_o);

// file: testbench/adcc_core_model.sv
// behavioural analog core answering start and abort pulses
module adcc_core_model #(
  parameter int LAT = 8           // cycles from start to finish
) (
  input  wire logic       clk_i,   // module clock
  input  wire logic       start_i, // start pulse
  input  wire logic       abort_i, // abort pulse
  input  wire logic [9:0] value_i, // value the conversion yields
  output logic            done_o,  // one-cycle finish pulse
  output logic      [9:0] result_o // valid with done only
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial done_o = 1'b0;
  // a start restarts even beside an abort; result is junk outside done
  always @(posedge clk_i) begin
    done_o <= cnt == 1;
    result_o <= (cnt == 1) ? value_i : ~value_i;
    if (start_i) cnt <= LAT;
    else if (abort_i) cnt <= 0;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule

// file: testbench/adcc_top_bench.sv
// self-checking bench for the conversion control block
module adcc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, hw = 0;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0, rd, prdata;
  logic        pready, perr, done, start, abort, pwr_on, irq, err;
  logic [9:0]  res, value = 10'h2A7;
  logic [4:0]  chan;
  logic [4:0]  m_codes [3] = '{5'h1C, 5'h1D, 5'h1E}; // reserved and reference codes
  int          fail_count = 0, cmp_count = 0, starts = 0, aborts = 0, cyc = 0, n, m;
  always #25 clk = ~clk;
  adcc_top DUT (.sys_clk_i(clk), .resetn_i(rstn), .ce_i(1'b1), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .hw_trigger_input_i(hw), .conv_done_i(done), .conv_result_i(res),
    .conv_start_o(start), .conv_abort_o(abort), .channel_o(chan), .power_on_o(pwr_on),
    .done_irq_o(irq));
  adcc_core_model #(.LAT(8)) u_core (.clk_i(clk), .start_i(start), .abort_i(abort),
    .value_i(value), .done_o(done), .result_o(res));
  // ==========================================================
  // monitors and hang guard
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
    if (abort === 1'b1) aborts++;
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, addr, wdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_idle();
    repeat (100) begin
      @(posedge clk);
      if (pwr_on === 1'b0) break;
    end
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rchk(6'h00, 32'h0000001F);
    rchk(6'h04, 32'h00000000);
    rchk(6'h1C, 32'h00000000);
    chk(32'(err), 32'h1);
    $display("reset test done");
  endtask
  task automatic t_single();
    n = starts;
    apb(1'b1, 6'h00, 32'h00000045);
    wait_idle();
    chk(32'(starts - n), 32'h1);
    chk(32'(irq), 32'h1);
    rchk(6'h00, 32'h000000C5);
    rchk(6'h08, 32'h00000002);
    value = 10'h0F0;
    apb(1'b1, 6'h00, 32'h00000045);
    wait_idle();
    rchk(6'h0C, 32'h000000A7);
    rchk(6'h00, 32'h00000045);
    chk(32'(irq), 32'h0);
    foreach (m_codes[i]) begin
      apb(1'b1, 6'h00, 32'(m_codes[i]));
      wait_idle();
      chk(32'(chan), 32'(m_codes[i]));
    end
    $display("single test done");
  endtask
  task automatic t_compare();
    apb(1'b1, 6'h10, 32'h1);
    apb(1'b1, 6'h14, 32'h0);
    apb(1'b1, 6'h04, 32'h20);
    value = 10'h155;
    apb(1'b1, 6'h00, 32'h5);
    wait_idle();
    rchk(6'h00, 32'h00000005);
    apb(1'b1, 6'h04, 32'h30);
    apb(1'b1, 6'h00, 32'h5);
    wait_idle();
    rchk(6'h00, 32'h00000085);
    apb(1'b1, 6'h04, 32'h0);
    apb(1'b1, 6'h18, 32'h0);
    apb(1'b1, 6'h00, 32'h5);
    wait_idle();
    rchk(6'h0C, 32'h00000055);
    rchk(6'h08, 32'h00000000);
    apb(1'b1, 6'h18, 32'h1);
    $display("compare test done");
  endtask
  task automatic t_cont();
    {n, m} = {starts, aborts};
    apb(1'b1, 6'h00, 32'h25);
    repeat (40) @(posedge clk);
    chk(32'(starts - n > 3), 32'h1);
    rchk(6'h04, 32'h00000080);
    apb(1'b1, 6'h00, 32'h1F);
    @(posedge clk);
    n = starts;
    repeat (20) @(posedge clk);
    chk(32'(starts), 32'(n));
    chk(32'(aborts - m), 32'h1);
    chk({31'h0, pwr_on}, 32'h0);
    chk(32'(chan), 32'h1F);
    $display("continuous test done");
  endtask
  task automatic t_hw();
    apb(1'b1, 6'h04, 32'h40);
    n = starts;
    apb(1'b1, 6'h00, 32'h3);
    repeat (10) @(posedge clk);
    chk(32'(starts), 32'(n));
    hw <= 1'b1;
    repeat (8) @(posedge clk);
    hw <= 1'b0;
    wait_idle();
    chk(32'(starts - n), 32'h1);
    chk(32'(chan), 32'h3);
    apb(1'b1, 6'h04, 32'h0);
    $display("trigger test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_single();
    t_compare();
    t_cont();
    t_hw();
    give_verdict();
  end
endmodule
